// >>> pmm_mem_map.sv
// Program counter wrap, vectors and banked data memory decoder
`timescale 1ns/100ps
module pmm_mem_map #(
    parameter int PROG_WORDS = pmm_pkg::PROG_WORDS
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        fetch_adv,
    input  wire logic        jump_valid,
    input  wire logic [12:0] jump_addr,
    input  wire logic        irq_take,
    output logic      [12:0] prog_addr,
    input  wire logic        dacc_valid,
    input  wire logic        dacc_write,
    input  wire logic [6:0]  dacc_ofs,
    input  wire logic [7:0]  dacc_wdata,
    output logic             rd_valid,
    output logic      [7:0]  rd_data,
    output logic             sfr_sel,
    output logic             sfr_write,
    output logic      [8:0]  sfr_addr,
    output logic      [7:0]  sfr_wdata,
    output logic      [1:0]  bank_sel
);
    localparam int PAW = $clog2(PROG_WORDS);
    localparam int GPR_DEPTH = pmm_pkg::BANKS * pmm_pkg::GPR_PER_BANK;
    localparam logic [12:0] PC_MASK = 13'((1 << PAW) - 1);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    logic [12:0] pc_r;
    logic [12:0] pc_nxt;
    logic [7:0]  status_r;
    logic [7:0]  indirect_pointer_r;
    logic        rd_valid_r;
    logic [7:0]  rd_data_r;
    logic        sfr_sel_r;
    logic        sfr_write_r;
    logic [8:0]  sfr_addr_r;
    logic [7:0]  sfr_wdata_r;

    logic        bank_select_high;
    logic        bank_select_low;
    logic [8:0]  full_addr;
    logic [6:0]  eff_ofs;
    logic [1:0]  eff_bank;
    logic        self_indirect;
    pmm_pkg::pmm_region_e region;
    logic [8:0]  gpr_index;

    pmm_ram_if #(.AW(pmm_pkg::GPR_AW), .DW(8)) ram_bus ();

    pmm_gpr_ram #(
        .DEPTH (GPR_DEPTH),
        .DW    (8)
    ) u_gpr (
        .clk (clk),
        .bus (ram_bus.mem)
    );

    // ---------------- Program side ----------------
    // Interrupt beats a jump, a jump beats the sequential step
    always_comb begin
        pc_nxt = pc_r;
        if (irq_take) begin
            pc_nxt = pmm_pkg::IRQ_VEC;
        end else if (jump_valid) begin
            pc_nxt = jump_addr;
        end else if (fetch_adv) begin
            pc_nxt = pc_r + 13'h0001;
        end
    end

    // Only the implemented low bits are kept, so any address wraps
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pc_r <= pmm_pkg::RESET_VEC;
        end else begin
            pc_r <= pc_nxt & PC_MASK;
        end
    end

    assign prog_addr = pc_r;

    // ---------------- Data side ----------------
    // Bank select lives in the status register, mirrored in all banks
    assign bank_select_high = status_r[pmm_pkg::BSEL_HI_BIT];
    assign bank_select_low  = status_r[pmm_pkg::BSEL_LO_BIT];

    // Direct uses bank bits over the offset; offset 00h goes via pointer
    always_comb begin
        self_indirect = 1'b0;
        if (dacc_ofs == pmm_pkg::OFS_INDIRECT) begin
            full_addr = {bank_select_high, indirect_pointer_r};
            self_indirect =
                (indirect_pointer_r[6:0] == pmm_pkg::OFS_INDIRECT);
        end else begin
            full_addr = {bank_select_high, bank_select_low,
                         dacc_ofs};
        end
        eff_bank = full_addr[8:7];
        eff_ofs  = full_addr[6:0];
    end

    // Region decode; every bank starts with its special area
    always_comb begin
        region = pmm_pkg::PMM_RGN_NONE;
        if (!dacc_valid || self_indirect) begin
            region = pmm_pkg::PMM_RGN_NONE;
        end else if (eff_ofs == pmm_pkg::OFS_STATUS ||
                     eff_ofs == pmm_pkg::OFS_POINTER) begin
            region = pmm_pkg::PMM_RGN_SFR_LOCAL;
        end else if (eff_ofs < pmm_pkg::SFR_TOP) begin
            region = pmm_pkg::PMM_RGN_SFR_EXT;
        end else begin
            region = pmm_pkg::PMM_RGN_GPR;
        end
    end

    // Bank-packed index: bank * 96 + (offset - 20h)
    assign gpr_index = 9'(eff_bank * pmm_pkg::GPR_PER_BANK)
                     + 9'(eff_ofs - pmm_pkg::SFR_TOP);

    assign ram_bus.we    = (region == pmm_pkg::PMM_RGN_GPR) && dacc_write;
    assign ram_bus.addr  = gpr_index;
    assign ram_bus.wdata = dacc_wdata;

    // Status register: one copy reached from every bank
    always_ff @(posedge clk) begin
        if (!resetn) begin
            status_r <= pmm_pkg::STATUS_RST;
        end else if (region == pmm_pkg::PMM_RGN_SFR_LOCAL && dacc_write &&
                     eff_ofs == pmm_pkg::OFS_STATUS) begin
            status_r <= dacc_wdata;
        end
    end

    // Indirect pointer, also mirrored in every bank
    always_ff @(posedge clk) begin
        if (!resetn) begin
            indirect_pointer_r <= pmm_pkg::POINTER_RST;
        end else if (region == pmm_pkg::PMM_RGN_SFR_LOCAL && dacc_write &&
                     eff_ofs == pmm_pkg::OFS_POINTER) begin
            indirect_pointer_r <= dacc_wdata;
        end
    end

    // Local read answers one cycle after the request
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_valid_r <= 1'b0;
            rd_data_r  <= 8'h00;
        end else begin
            rd_valid_r <= 1'b0;
            if (dacc_valid && !dacc_write) begin
                if (region == pmm_pkg::PMM_RGN_GPR) begin
                    rd_valid_r <= 1'b1;
                    rd_data_r  <= ram_bus.rdata;
                end else if (region == pmm_pkg::PMM_RGN_SFR_LOCAL) begin
                    rd_valid_r <= 1'b1;
                    rd_data_r  <= (eff_ofs == pmm_pkg::OFS_STATUS) ?
                                  status_r : indirect_pointer_r;
                end else if (region == pmm_pkg::PMM_RGN_NONE) begin
                    rd_valid_r <= 1'b1;                // Self-indirect reads 0
                    rd_data_r  <= 8'h00;
                end
            end
        end
    end

    // Peripheral strobe; mirrored registers fold to their bank 0 address
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sfr_sel_r   <= 1'b0;
            sfr_write_r <= 1'b0;
            sfr_addr_r  <= 9'h000;
            sfr_wdata_r <= 8'h00;
        end else begin
            sfr_sel_r   <= (region == pmm_pkg::PMM_RGN_SFR_EXT);
            sfr_write_r <= (region == pmm_pkg::PMM_RGN_SFR_EXT) && dacc_write;
            if (region == pmm_pkg::PMM_RGN_SFR_EXT) begin
                sfr_wdata_r <= dacc_wdata;
                if (pmm_pkg::pmm_is_mirrored(eff_ofs)) begin
                    sfr_addr_r <= {2'b00, eff_ofs};
                end else begin
                    sfr_addr_r <= full_addr;
                end
            end
        end
    end

    assign rd_valid  = rd_valid_r;
    assign rd_data   = rd_data_r;
    assign sfr_sel   = sfr_sel_r;
    assign sfr_write = sfr_write_r;
    assign sfr_addr  = sfr_addr_r;
    assign sfr_wdata = sfr_wdata_r;
    assign bank_sel  = {status_r[pmm_pkg::BSEL_HI_BIT],
                        status_r[pmm_pkg::BSEL_LO_BIT]};

    // ---------------- Checks ----------------
    a_reset_vector_start: assert property (
        !$past(resetn) |-> pc_r == 13'h0000)
        else $error("pc not at zero after reset");

    a_irq_vector_jump: assert property (
        irq_take |=> pc_r == 13'h0004)
        else $error("interrupt did not vector to four");

    a_pc_wrap_range: assert property (
        int'(pc_r) < PROG_WORDS)
        else $error("pc beyond implemented memory");

    a_pc_step_wrap: assert property (
        fetch_adv && !jump_valid && !irq_take
        |=> pc_r == (($past(pc_r) + 13'h0001) & PC_MASK))
        else $error("pc step or wrap wrong");

    a_gpr_read_path: assert property (
        dacc_valid && !dacc_write && dacc_ofs >= 7'h20
        |=> rd_valid && !sfr_sel)
        else $error("upper offset did not hit storage");

    a_sfr_low_area: assert property (
        dacc_valid && dacc_ofs != 7'h00 && dacc_ofs < 7'h20 &&
        dacc_ofs != 7'h03 && dacc_ofs != 7'h04
        |=> sfr_sel && sfr_addr[6:0] == $past(dacc_ofs))
        else $error("low offset did not select a special register");

    a_sfr_mirror_fold: assert property (
        sfr_sel && pmm_pkg::pmm_is_mirrored(sfr_addr[6:0])
        |-> sfr_addr[8:7] == 2'b00)
        else $error("mirrored register not folded");

    a_bank_from_status: assert property (
        dacc_valid && dacc_write && dacc_ofs == 7'h03
        |=> bank_sel == $past(dacc_wdata[6:5]))
        else $error("bank select not taken from status");

    a_direct_bank_addr: assert property (
        dacc_valid && dacc_ofs > 7'h0B && dacc_ofs < 7'h20
        |=> sfr_addr == {$past(bank_sel), $past(dacc_ofs)})
        else $error("direct address not bank over offset");

    a_ptr_indirect: assert property (
        dacc_valid && dacc_write && dacc_ofs == 7'h04
        |=> dacc_valid && !dacc_write && dacc_ofs == 7'h04
        |=> rd_valid && rd_data == $past(dacc_wdata, 2))
        else $error("pointer write not visible");

    a_split_buses: assert property (
        fetch_adv && !jump_valid && !irq_take && dacc_valid &&
        !dacc_write && dacc_ofs >= 7'h20
        |=> pc_r != $past(pc_r) && rd_valid)
        else $error("fetch and data access did not run together");
endmodule // pmm_mem_map

// >>> pmm_pkg.sv
// Constants and types for the program and data memory map decoder
package pmm_pkg;
    localparam int PC_W        = 13;
    localparam int WORD_W      = 14;
    localparam int PROG_WORDS  = 8192;
    localparam logic [12:0] RESET_VEC = 13'h0000;
    localparam logic [12:0] IRQ_VEC   = 13'h0004;

    localparam int OFS_W       = 7;
    localparam int DADDR_W     = 9;
    localparam int BANK_BYTES  = 128;
    localparam int BANKS       = 4;
    localparam logic [6:0] SFR_TOP   = 7'h20;
    localparam int GPR_PER_BANK = 96;
    localparam int GPR_AW      = 9;

    localparam logic [6:0] OFS_INDIRECT = 7'h00;
    localparam logic [6:0] OFS_PCL      = 7'h02;
    localparam logic [6:0] OFS_STATUS   = 7'h03;
    localparam logic [6:0] OFS_POINTER  = 7'h04;
    localparam logic [6:0] OFS_PCLATH   = 7'h0A;
    localparam logic [6:0] OFS_INTCTL   = 7'h0B;

    localparam int BSEL_HI_BIT = 6;
    localparam int BSEL_LO_BIT = 5;
    localparam logic [7:0] STATUS_RST  = 8'h00;
    localparam logic [7:0] POINTER_RST = 8'h00;

    // Where a data access lands
    typedef enum logic [1:0] {
        PMM_RGN_NONE,
        PMM_RGN_SFR_EXT,
        PMM_RGN_SFR_LOCAL,
        PMM_RGN_GPR
    } pmm_region_e;

    // Special registers that appear at the same offset in every bank
    function automatic logic pmm_is_mirrored(input logic [6:0] ofs);
        return (ofs == OFS_INDIRECT) || (ofs == OFS_PCL) ||
               (ofs == OFS_STATUS) || (ofs == OFS_POINTER) ||
               (ofs == OFS_PCLATH) || (ofs == OFS_INTCTL);
    endfunction
endpackage

// >>> pmm_ram_if.sv
// Carrier between the decoder and its general purpose storage
`timescale 1ns/100ps
interface pmm_ram_if #(
    parameter int AW = 9,
    parameter int DW = 8
);
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    modport ctl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface

// >>> pmm_gpr_ram.sv
// General purpose register storage built from flip-flops
`timescale 1ns/100ps
module pmm_gpr_ram #(
    parameter int DEPTH = 384,
    parameter int DW    = 8
) (
    input  wire logic clk,
    pmm_ram_if.mem    bus
);
    logic [DW-1:0] cell_r [DEPTH];

    // Write port; no reset, contents are undefined like real SRAM
    always_ff @(posedge clk) begin
        if (bus.we && (int'(bus.addr) < DEPTH)) begin
            cell_r[bus.addr] <= bus.wdata;
        end
    end

    // Read is combinational; the decoder registers it
    always_comb begin
        bus.rdata = '0;
        if (int'(bus.addr) < DEPTH) begin
            bus.rdata = cell_r[bus.addr];
        end
    end
endmodule // pmm_gpr_ram

// >>> pmm_sfr_model.sv
// Peripheral register file model capturing external special writes
`timescale 1ns/100ps
module pmm_sfr_model (
    input  wire logic        clk,
    input  wire logic        sfr_sel,
    input  wire logic        sfr_write,
    input  wire logic [8:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [15:0] wr_count
);
    logic [7:0]  regs_r [512];
    logic [15:0] count_r = 16'h0000;
    // Capture writes; mirrored registers land at bank 0 only
    always @(posedge clk) begin
        if (sfr_sel === 1'b1 && sfr_write === 1'b1) begin
            regs_r[sfr_addr] <= sfr_wdata;
            count_r <= count_r + 16'h0001;
        end
    end

    // One driver for the count seen by the bench
    assign wr_count = count_r;
endmodule // pmm_sfr_model

// >>> pmm_mem_map_tb.sv
// Self-checking bench for the memory map decoder
`timescale 1ns/100ps
module pmm_mem_map_tb;
    localparam int PW = 4096; // Small variant keeps the wrap reachable
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        fetch_adv = 1'b0;
    logic        jump_valid = 1'b0;
    logic [12:0] jump_addr = 13'h0000;
    logic        irq_take = 1'b0;
    logic        dacc_valid = 1'b0;
    logic        dacc_write = 1'b0;
    logic [6:0]  dacc_ofs = 7'h00;
    logic [7:0]  dacc_wdata = 8'h00;
    logic [12:0] prog_addr;
    logic        rd_valid;
    logic        sfr_sel;
    logic        sfr_write;
    logic [7:0]  rd_data;
    logic [7:0]  sfr_wdata;
    logic [8:0]  sfr_addr;
    logic [1:0]  bank_sel;
    logic [15:0] sfr_seen;
    logic [18:0] exp_q[$];
    logic [7:0]  shadow [512];
    logic [12:0] pc_m = 13'h0000;
    logic [7:0]  stat = 8'h00;
    logic [1:0]  bank_q = 2'b00;
    logic [7:0]  ptr = 8'h00;
    logic [31:0] r;
    int          mismatches = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          sfr_writes = 0;
    integer      seed = 32'heb081aad;

    pmm_mem_map #(.PROG_WORDS(PW)) DUT (.clk(clk), .resetn(resetn),
        .fetch_adv(fetch_adv), .jump_valid(jump_valid),
        .jump_addr(jump_addr), .irq_take(irq_take), .prog_addr(prog_addr),
        .dacc_valid(dacc_valid), .dacc_write(dacc_write),
        .dacc_ofs(dacc_ofs), .dacc_wdata(dacc_wdata), .rd_valid(rd_valid),
        .rd_data(rd_data), .sfr_sel(sfr_sel), .sfr_write(sfr_write),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .bank_sel(bank_sel));

    pmm_sfr_model PERI (.clk(clk), .sfr_sel(sfr_sel), .sfr_write(sfr_write),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .wr_count(sfr_seen));

    always #2.5 clk = ~clk;

    task automatic check(input logic [18:0] seen, input logic [18:0] exp,
                         input string what);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen,
                     exp);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // One data access; notes the answer it expects before the edge
    task automatic acc(input logic w, input logic [6:0] o,
                       input logic [7:0] d);
        logic [8:0] a;
        logic       mir;
        @(posedge clk);
        // Decode after the edge, so a status or pointer write just made
        // has already settled in the shadow copies
        a = (o == 7'h00) ? {stat[6], ptr} : {stat[6:5], o};
        mir = a[6:0] inside {7'h02, 7'h0A, 7'h0B};
        dacc_valid <= 1'b1;
        dacc_write <= w;
        dacc_ofs <= o;
        dacc_wdata <= d;
        if (a[6:0] == 7'h00) begin
            if (!w) exp_q.push_back(19'h0_0000);
        end else if (a[6:0] == 7'h03) begin
            if (w) stat <= d;
            else exp_q.push_back({11'h000, stat});
        end else if (a[6:0] == 7'h04) begin
            if (w) ptr <= d;
            else exp_q.push_back({11'h000, ptr});
        end else if (a[6:0] >= 7'h20) begin
            if (w) shadow[a] = d;
            else exp_q.push_back({2'b00, 9'h000, shadow[a]});
        end else begin
            if (mir) a = {2'b00, a[6:0]};
            exp_q.push_back({1'b1, w, a, d});
            if (w) begin
                shadow[a] = d;
                sfr_writes++;
            end
        end
    endtask

    // Reference fetch address and timeout; reads inputs before the edge
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            mismatches++;
            conclude();
        end
        bank_q = stat[6:5];
        if (!resetn) pc_m = 13'h0000;
        else if (irq_take) pc_m = 13'h0004;
        else if (jump_valid) pc_m = jump_addr & 13'(PW - 1);
        else if (fetch_adv) pc_m = (pc_m + 13'h0001) & 13'(PW - 1);
    end

    // Watcher: settled outputs taken at the falling edge
    always @(negedge clk) begin
        check({6'h00, prog_addr}, {6'h00, pc_m}, "fetch");
        check({17'h0, bank_sel}, {17'h0, bank_q}, "bank");
        if (rd_valid === 1'b1 || sfr_sel === 1'b1) begin
            if (exp_q.size() == 0) check(19'h7_FFFF, 19'h0, "stray answer");
            else check({sfr_sel, sfr_write, rd_valid ? 9'h000 : sfr_addr,
                rd_valid ? rd_data : sfr_wdata}, exp_q.pop_front(),
                "answer");
        end
    end

    // Program side: wrap at the top, then random steps, jumps and vectors
    initial begin
        repeat (3) @(posedge clk);
        jump_valid <= 1'b1;
        jump_addr <= 13'h1FFE;
        @(posedge clk);
        jump_valid <= 1'b0;
        fetch_adv <= 1'b1;
        repeat (3) @(posedge clk);
        forever begin
            @(posedge clk);
            r = $random(seed);
            fetch_adv <= r[0];
            jump_valid <= (r[3:1] == 3'h0);
            irq_take <= (r[6:4] == 3'h0);
            jump_addr <= r[20:8];
        end
    end

    // Data side: every bank, storage edges, specials, mirrors, pointer
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        for (int b = 0; b < 4; b++) begin
            acc(1'b1, 7'h03, {1'b0, b[1:0], 5'h00});
            acc(1'b1, 7'h20, 8'($random(seed)));
            acc(1'b1, 7'h7F, 8'($random(seed)));
            acc(1'b1, 7'h05, 8'($random(seed)));
            acc(1'b1, 7'h1F, 8'($random(seed)));
            acc(1'b1, 7'h0A, 8'($random(seed)));
        end
        for (int b = 0; b < 4; b++) begin
            acc(1'b1, 7'h03, {1'b0, b[1:0], 5'h00});
            acc(1'b0, 7'h20, 8'h00);
            acc(1'b0, 7'h7F, 8'h00);
        end
        acc(1'b1, 7'h04, 8'hA0);
        acc(1'b0, 7'h04, 8'h00);
        acc(1'b1, 7'h00, 8'($random(seed)));
        acc(1'b1, 7'h03, 8'h20);
        acc(1'b0, 7'h03, 8'h00);
        acc(1'b0, 7'h20, 8'h00);
        acc(1'b0, 7'h00, 8'h00);
        acc(1'b1, 7'h04, 8'h80);
        acc(1'b0, 7'h00, 8'h00);
        acc(1'b1, 7'h00, 8'h3C);
        acc(1'b0, 7'h20, 8'h00);
        acc(1'b1, 7'h04, 8'h8A);
        acc(1'b1, 7'h00, 8'h5A);
        acc(1'b0, 7'h15, 8'h00);
        @(posedge clk);
        dacc_valid <= 1'b0;
        repeat (4) @(posedge clk);
        check({11'h000, PERI.regs_r[9'h00A]}, {11'h000, shadow[9'h00A]},
              "mirror in peripheral");
        check(19'(exp_q.size()), 19'h0, "answers missing");
        check({3'h0, sfr_seen}, 19'(sfr_writes), "special writes");
        conclude();
    end
endmodule // pmm_mem_map_tb
